// file: dv/dcc_mem_model.sv
// behavioural memory and peripheral behind the bus master port
`default_nettype none
module dcc_mem_model (
  // clock, reset and pace
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] dly_i,
  // bus from the engine
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic ack_o,
  // last write and write count
  output logic [23:0] waddr_o,
  output logic [15:0] wd_o,
  output logic [15:0] nwr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // data valid only with ack; inverse otherwise so stale data never matches
  assign rdata_o = ack_o ? ~addr_i[15:0] : addr_i[15:0];
  // one ack per bus cycle after dly_i wait cycles
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      nwr_o <= 16'h0000;
      waddr_o <= 24'h000000;
      wd_o <= 16'h0000;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      if (we_i) begin
        waddr_o <= addr_i;
        wd_o <= wdata_i;
        nwr_o <= nwr_o + 16'h0001;
      end
    end else if (req_i) begin
      if (wait_q >= dly_i) ack_o <= 1'b1;
      else wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/dcc_properties.sv
// assertions on the ports of the dma control block
`include "dcc_consts.svh"
`default_nettype none
module dcc_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // watched controls
  input wire logic [`DCC_NCH-1:0] full_addr_i,
  input wire logic nmi_i,
  input wire logic [`DCC_NSUB-1:0] xfer_en_i,
  input wire logic [`DCC_NSUB-1:0] ack_en_i,
  input wire logic [`DCC_NSUB-1:0] irq_en_i,
  input wire logic [`DCC_NCH-1:0] single_b_i,
  input wire logic bus_ack_i,
  // watched outputs
  input wire logic [`DCC_NCH-1:0] master_en_o,
  input wire logic [`DCC_NSUB-1:0] clr_src_o,
  input wire logic [`DCC_NSUB-1:0] end_irq_o,
  input wire logic bus_req_o,
  input wire logic bus_we_o,
  input wire logic [`DCC_ADDR_W-1:0] bus_addr_o,
  input wire logic [`DCC_NSUB-1:0] dack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ====
  // single address cycle of 0b begins
  sequence s_single_go;
    $rose(dack_o[1]);
  endsequence
  property p_master;
    s_single_go |-> $past(master_en_o[0]);
  endproperty
  a_master: assert property (p_master) else $error("grant with master off");
  property p_nmi;
    nmi_i && !full_addr_i[0] |=> !master_en_o[0];
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi left master on");
  // pulse lasts one cycle and follows the final write ack
  property p_clr;
    clr_src_o[0] |-> $past(bus_ack_i && bus_we_o && ack_en_i[0]) ##1 !clr_src_o[0];
  endproperty
  a_clr: assert property (p_clr) else $error("bad source clear");
  property p_short;
    dack_o[1] && !full_addr_i[0] |-> bus_addr_o[23:16] == `DCC_SHORT_HI;
  endproperty
  a_short: assert property (p_short) else $error("short address high byte");
  property p_irq;
    end_irq_o[0] |-> irq_en_i[0];
  endproperty
  a_irq: assert property (p_irq) else $error("end interrupt not gated");
  property p_subon;
    s_single_go |-> $past(xfer_en_i[1]);
  endproperty
  a_subon: assert property (p_subon) else $error("grant with sub off");
  property p_single;
    dack_o[1] |-> !bus_we_o && bus_req_o && single_b_i[0];
  endproperty
  a_single: assert property (p_single) else $error("single cycle wrong");
  property p_dual_a;
    !dack_o[0] && !dack_o[2];
  endproperty
  a_dual_a: assert property (p_dual_a) else $error("a sub went single");
endmodule
bind dcc_top dcc_properties chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .full_addr_i(full_addr_i),
  .nmi_i(nmi_i), .xfer_en_i(xfer_en_i), .ack_en_i(ack_en_i), .irq_en_i(irq_en_i),
  .single_b_i(single_b_i), .bus_ack_i(bus_ack_i), .master_en_o(master_en_o), .clr_src_o(clr_src_o),
  .end_irq_o(end_irq_o), .bus_req_o(bus_req_o), .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o),
  .dack_o(dack_o));
`default_nettype wire

// file: dv/tb.sv
// self-checking bench of the dma control block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rn = 0, nmi = 0, req, we, ack, busy;
  logic [1:0] mset = 0, mclr = 0, full = 0, sgl = 0, men;
  logic [3:0] xen = 4'hf, acken = 4'hf, irqen = 4'hf, st = 0, ecl = 0, act = 0, clr, eirq, dack;
  logic [3:0] dly = 0;
  logic [15:0] rd, wd, lwd, wcnt, n;
  logic [15:0] cntv = 16'h0001;
  logic [23:0] ad, wa;
  int err_total = 0, n_compared = 0, cyc = 0, nclr = 0, nd = 0;
  initial forever #5 clk = ~clk;
  dcc_top dut_u (.clock_i(clk), .rst_n_i(rn), .master_set_i(mset), .master_clr_i(mclr),
    .full_addr_i(full), .nmi_i(nmi), .xfer_en_i(xen), .ack_en_i(acken), .irq_en_i(irqen),
    .single_b_i(sgl), .start_i(st), .count_i(cntv), .src_addr_i(24'h012340),
    .dst_addr_i(24'h056780), .end_clr_i(ecl), .act_i(act), .master_en_o(men), .clr_src_o(clr),
    .end_irq_o(eirq), .busy_o(busy), .bus_req_o(req), .bus_we_o(we), .bus_addr_o(ad),
    .bus_wdata_o(wd), .bus_rdata_i(rd), .bus_ack_i(ack), .dack_o(dack));
  dcc_mem_model mem_u (.clk_i(clk), .rst_n_i(rn), .dly_i(dly), .req_i(req), .we_i(we), .addr_i(ad),
    .wdata_i(wd), .rdata_o(rd), .ack_o(ack), .waddr_o(wa), .wd_o(lwd), .nwr_o(wcnt));
  // event counters and a ceiling on run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (clr[0]) nclr <= nclr + 1;
    if (dack[1] && ack) nd <= nd + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end
  // ====
  // tasks
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // load and activate one transfer; bounded wait for the engine to go idle
  task automatic go(int s);
    st[s] = 1;
    @(negedge clk);
    st[s] = 0;
    act[s] = 1;
    @(negedge clk);
    act[s] = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (i > 5 && !busy) break;
    end
    // one more edge so the event counters, sampled on the rising edge, have caught up
    @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ====
  // tests
  initial begin
    repeat (2) @(negedge clk);
    rn = 1;
    go(0);
    chk("writes", 0, wcnt);
    chk("busy", 0, busy);
    $display("end master off");
    mset = 2'h3;
    dly = 3;
    @(negedge clk);
    mset = 0;
    go(0);
    chk("waddr", 24'hff6780, wa);
    chk("wdata", 24'h00dcbf, lwd);
    chk("clr", 1, nclr);
    chk("irq", 1, eirq[0]);
    $display("end short dual");
    acken = 0;
    irqen = 0;
    ecl = 4'hf;
    dly = 0;
    @(negedge clk);
    ecl = 0;
    go(0);
    chk("clr", 1, nclr);
    chk("irq", 0, eirq[0]);
    irqen = 4'hf;
    @(negedge clk);
    chk("irq", 1, eirq[0]);
    $display("end enables off");
    sgl = 2'h1;
    n = wcnt;
    go(1);
    chk("dack", 1, nd);
    chk("writes", n, wcnt);
    $display("end single");
    xen = 4'he;
    go(0);
    chk("writes", n, wcnt);
    full = 2'h2;
    go(2);
    chk("waddr", 24'h056780, wa);
    $display("end full");
    // two-transfer run on 1b: no end interrupt until the count is used up
    cntv = 16'h0002;
    go(3);
    cntv = 16'h0001;
    chk("writes", n + 16'h0002, wcnt);
    chk("irq", 0, eirq[3]);
    act[3] = 1;
    @(negedge clk);
    act[3] = 0;
    repeat (12) @(negedge clk);
    chk("waddr", 24'h056781, wa);
    chk("irq", 1, eirq[3]);
    $display("end count two");
    nmi = 1;
    @(negedge clk);
    nmi = 0;
    chk("men", 2'h2, men);
    $display("end nmi");
    wrap_up();
  end
endmodule
`default_nettype wire

// file: logic/dcc_subch.sv
// one dma sub-channel: pending request, transfer count, source clear and end flag
`include "dcc_consts.svh"
`default_nettype none
module dcc_subch
  import dcc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic ack_en_i,
  input wire logic irq_en_i,
  input wire logic start_i,
  input wire logic [`DCC_CNT_W-1:0] count_i,
  input wire logic end_clr_i,
  // activation and service
  input wire logic act_i,
  input wire logic served_i,
  // status
  output logic pend_o,
  output logic clr_src_o,
  output logic end_irq_o,
  output logic [`DCC_CNT_W-1:0] left_o
);
  logic pend_reg;
  logic [`DCC_CNT_W-1:0] cnt_reg;
  logic clr_reg;
  logic end_reg;
  logic last_w;

  assign last_w = served_i && (cnt_reg == `DCC_CNT_W'(1));

  // request latch; a new activation in the serving cycle is kept
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pend_reg <= 1'b0;
    end else if (act_i) begin
      pend_reg <= 1'b1;
    end else if (served_i || start_i) begin
      pend_reg <= 1'b0;
    end
  end

  // remaining transfers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_reg <= `DCC_CNT_RST;
    end else if (start_i) begin
      cnt_reg <= count_i;
    end else if (served_i && cnt_reg != `DCC_CNT_RST) begin
      cnt_reg <= cnt_reg - `DCC_CNT_W'(1);
    end
  end

  // source clear strobe, one cycle per finished transfer while ack_en_i is set
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= served_i && ack_en_i; // RULE_03
    end
  end

  // sticky end flag; the set beats a clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      end_reg <= 1'b0;
    end else if (last_w) begin
      end_reg <= 1'b1;
    end else if (end_clr_i) begin
      end_reg <= 1'b0;
    end
  end

  // held off while the channel or sub-channel is disabled
  assign pend_o = pend_reg && run_i && (cnt_reg != `DCC_CNT_RST);
  assign clr_src_o = clr_reg;
  assign end_irq_o = end_reg && irq_en_i; // RULE_05
  assign left_o = cnt_reg;
endmodule
`default_nettype wire

// file: logic/dcc_top.sv
// two-channel dma engine with control bits and a shared bus master port
`include "dcc_consts.svh"
`default_nettype none
module dcc_top
  import dcc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // channel control, index 0 is channel 0
  input wire logic [`DCC_NCH-1:0] master_set_i,
  input wire logic [`DCC_NCH-1:0] master_clr_i,
  input wire logic [`DCC_NCH-1:0] full_addr_i,
  input wire logic nmi_i,
  // sub-channel control, index 0a 0b 1a 1b; single_b_i is indexed by channel
  input wire logic [`DCC_NSUB-1:0] xfer_en_i,
  input wire logic [`DCC_NSUB-1:0] ack_en_i,
  input wire logic [`DCC_NSUB-1:0] irq_en_i,
  input wire logic [`DCC_NCH-1:0] single_b_i,
  // sub-channel setup
  input wire logic [`DCC_NSUB-1:0] start_i,
  input wire logic [`DCC_CNT_W-1:0] count_i,
  input wire logic [`DCC_ADDR_W-1:0] src_addr_i,
  input wire logic [`DCC_ADDR_W-1:0] dst_addr_i,
  input wire logic [`DCC_NSUB-1:0] end_clr_i,
  // activation from internal sources
  input wire logic [`DCC_NSUB-1:0] act_i,
  // status
  output logic [`DCC_NCH-1:0] master_en_o,
  output logic [`DCC_NSUB-1:0] clr_src_o,
  output logic [`DCC_NSUB-1:0] end_irq_o,
  output logic busy_o,
  // bus master port
  output logic bus_req_o,
  output logic bus_we_o,
  output logic [`DCC_ADDR_W-1:0] bus_addr_o,
  output logic [`DCC_DATA_W-1:0] bus_wdata_o,
  input wire logic [`DCC_DATA_W-1:0] bus_rdata_i,
  input wire logic bus_ack_i,
  // single address acknowledge to the peripheral
  output logic [`DCC_NSUB-1:0] dack_o
);
  // ==========================================================
  // storage
  logic [`DCC_NCH-1:0] men_reg;
  logic [`DCC_ADDR_W-1:0] src_reg [`DCC_NSUB];
  logic [`DCC_ADDR_W-1:0] dst_reg [`DCC_NSUB];
  dcc_state_t state_reg;
  dcc_sel_t sel_reg;
  logic req_reg;
  logic we_reg;
  logic [`DCC_ADDR_W-1:0] addr_reg;
  logic [`DCC_DATA_W-1:0] data_reg;
  logic [`DCC_NSUB-1:0] dack_reg;
  logic [`DCC_NSUB-1:0] pend_w;
  logic [`DCC_NSUB-1:0] run_w;
  logic [`DCC_NSUB-1:0] served_w;
  logic [`DCC_NSUB-1:0] single_w;
  logic [`DCC_NSUB-1:0] full_w;
  logic done_w;
  logic grant_any_w;
  dcc_sel_t grant_w;

  // ==========================================================
  // master enables
  // in short address mode nmi wins over a software set in the same cycle: stopping is the safe side
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      men_reg <= `DCC_MEN_RST;
    end else begin
      for (int c = 0; c < `DCC_NCH; c++) begin
        if (nmi_i && !full_addr_i[c]) begin
          men_reg[c] <= 1'b0; // RULE_02
        end else if (master_clr_i[c]) begin
          men_reg[c] <= 1'b0;
        end else if (master_set_i[c]) begin
          men_reg[c] <= 1'b1;
        end
      end
    end
  end

  // per sub-channel run, mode and address-mode views
  always_comb begin
    for (int s = 0; s < `DCC_NSUB; s++) begin
      run_w[s] = men_reg[s / 2] && xfer_en_i[s]; // RULE_01 RULE_06
      full_w[s] = full_addr_i[s / 2]; // RULE_04
      single_w[s] = (s % 2 == 1) && single_b_i[s / 2]; // RULE_07
    end
  end

  // ==========================================================
  // sub-channels
  for (genvar g = 0; g < `DCC_NSUB; g++) begin : g_sub
    dcc_subch u_sub (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .run_i(run_w[g]),
      .ack_en_i(ack_en_i[g]),
      .irq_en_i(irq_en_i[g]),
      .start_i(start_i[g]),
      .count_i(count_i),
      .end_clr_i(end_clr_i[g]),
      .act_i(act_i[g]),
      .served_i(served_w[g]),
      .pend_o(pend_w[g]),
      .clr_src_o(clr_src_o[g]),
      .end_irq_o(end_irq_o[g]),
      .left_o()
    );
  end

  // addresses captured at start, advanced after each transfer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < `DCC_NSUB; s++) begin
        src_reg[s] <= `DCC_ADDR_RST;
        dst_reg[s] <= `DCC_ADDR_RST;
      end
    end else begin
      for (int s = 0; s < `DCC_NSUB; s++) begin
        if (start_i[s]) begin
          src_reg[s] <= src_addr_i;
          dst_reg[s] <= dst_addr_i;
        end else if (served_w[s]) begin
          src_reg[s] <= src_reg[s] + `DCC_ADDR_W'(1);
          dst_reg[s] <= dst_reg[s] + `DCC_ADDR_W'(1);
        end
      end
    end
  end

  // short mode keeps 16 address bits and fills the top with ones
  function automatic logic [`DCC_ADDR_W-1:0] dcc_form(input logic full, input logic [`DCC_ADDR_W-1:0] a);
    logic [`DCC_ADDR_W-1:0] r;
    r = full ? a : {`DCC_SHORT_HI, a[`DCC_SHORT_W-1:0]}; // RULE_04
    return r;
  endfunction

  // ==========================================================
  // fixed priority 0a over 0b over 1a over 1b
  always_comb begin
    grant_any_w = 1'b0;
    grant_w = 2'h0;
    for (int s = `DCC_NSUB - 1; s >= 0; s--) begin
      if (pend_w[s]) begin
        grant_any_w = 1'b1;
        grant_w = dcc_sel_t'(s);
      end
    end
  end

  // the last bus cycle of a transfer has been acknowledged
  assign done_w = bus_ack_i && ((state_reg == DCC_ST_WRITE) || (state_reg == DCC_ST_SINGLE));

  always_comb begin
    served_w = '0;
    served_w[sel_reg] = done_w;
  end

  // ==========================================================
  // engine sequencing
  // a bus cycle already started runs to its ack even if the enable drops
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= DCC_ST_IDLE;
      sel_reg <= 2'h0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= `DCC_ADDR_RST;
      data_reg <= `DCC_DATA_RST;
      dack_reg <= '0;
    end else begin
      unique case (state_reg)
        DCC_ST_IDLE: begin
          if (grant_any_w) begin
            sel_reg <= grant_w;
            req_reg <= 1'b1;
            if (single_w[grant_w]) begin
              // one bus cycle, peripheral is strobed by dack
              state_reg <= DCC_ST_SINGLE; // RULE_07
              we_reg <= 1'b0;
              addr_reg <= dcc_form(full_w[grant_w], dst_reg[grant_w]);
              dack_reg <= `DCC_NSUB'(1) << grant_w;
            end else begin
              state_reg <= DCC_ST_READ;
              we_reg <= 1'b0;
              addr_reg <= dcc_form(full_w[grant_w], src_reg[grant_w]);
            end
          end
        end
        DCC_ST_READ: begin
          if (bus_ack_i) begin
            state_reg <= DCC_ST_WRITE;
            data_reg <= bus_rdata_i;
            we_reg <= 1'b1;
            addr_reg <= dcc_form(full_w[sel_reg], dst_reg[sel_reg]);
          end
        end
        DCC_ST_WRITE: begin
          if (bus_ack_i) begin
            state_reg <= DCC_ST_IDLE;
            req_reg <= 1'b0;
            we_reg <= 1'b0;
          end
        end
        DCC_ST_SINGLE: begin
          if (bus_ack_i) begin
            state_reg <= DCC_ST_IDLE;
            req_reg <= 1'b0;
            dack_reg <= '0;
          end
        end
        default: begin
          state_reg <= DCC_ST_IDLE;
          req_reg <= 1'b0;
          we_reg <= 1'b0;
          dack_reg <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign master_en_o = men_reg;
  assign busy_o = (state_reg != DCC_ST_IDLE);
  assign bus_req_o = req_reg;
  assign bus_we_o = we_reg;
  assign bus_addr_o = addr_reg;
  assign bus_wdata_o = data_reg;
  assign dack_o = dack_reg;
endmodule
`default_nettype wire

// file: shared/dcc_consts.svh
// constants of the two-channel dma control block
// Function
// RULE_01: channel transfers run only while that channel's master enable is set.
// RULE_02: in short address mode a non-maskable interrupt clears the master enable.
// RULE_03: with acknowledge set, each transfer clears the selected internal source flag.
// RULE_04: full address enable set means full address mode, clear means short mode.
// RULE_05: interrupt enable set lets transfer end raise an interrupt, else suppressed.
// RULE_06: each sub-channel transfers only while its own transfer enable is set.
// RULE_07: on B sub-channels single address enable picks single, else dual address.
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
// ==========================================================
// widths and counts
`define DCC_NSUB 4
`define DCC_NCH 2
`define DCC_ADDR_W 24
`define DCC_SHORT_W 16
`define DCC_DATA_W 16
`define DCC_CNT_W 16
// ==========================================================
// address and reset values
`define DCC_SHORT_HI 8'hff
`define DCC_MEN_RST 2'h0
`define DCC_CNT_RST 16'h0000
`define DCC_ADDR_RST 24'h000000
`define DCC_DATA_RST 16'h0000
// ==========================================================
// sub-channel numbering, 0a 0b 1a 1b
`define DCC_SUB_0A 0
`define DCC_SUB_0B 1
`define DCC_SUB_1A 2
`define DCC_SUB_1B 3
`endif

// file: shared/dcc_pkg.sv
// types of the two-channel dma control block
`default_nettype none
package dcc_pkg;
  // ==========================================================
  // engine state, one-hot
  typedef enum logic [3:0] {
    DCC_ST_IDLE = 4'h1,
    DCC_ST_READ = 4'h2,
    DCC_ST_WRITE = 4'h4,
    DCC_ST_SINGLE = 4'h8
  } dcc_state_t;
  typedef logic [1:0] dcc_sel_t;
endpackage
`default_nettype wire
